// [usb_flags_top.sv]
// Global interrupt flag block with its AXI4-Lite register slave.
`timescale 1ns/1ps
module usb_flags_top #(
	parameter int IDLE_CYCLES = usb_flags_pkg::IDLE_CYCLES
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic BVALID,
	output logic [1:0] BRESP,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic RVALID,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	input wire logic RREADY,
	input wire logic HOST_MODE,
	input wire logic IN_EP_PENDING,
	input wire logic DUAL_ROLE_PENDING,
	input wire logic FRAME_MARK,
	input wire logic [1:0] FRAME_MARK_POINT,
	input wire logic ISO_OUT_DROP,
	input wire logic ENUM_DONE,
	input wire logic [1:0] ENUM_SPEED,
	input wire logic BUS_RESET,
	input wire logic BUS_IDLE,
	input wire logic OUT_NACK_ACTIVE,
	input wire logic IN_NACK_ACTIVE,
	input wire logic TX_HALF_EMPTY,
	input wire logic TX_EMPTY,
	input wire logic RX_NONEMPTY,
	input wire logic SOF_PREPARE,
	input wire logic SOF_RECEIVED,
	input wire logic [10:0] SOF_FRAME,
	output logic IRQ,
	output logic OUT_NACK_REQ,
	output logic IN_NACK_REQ,
	output logic SUSPENDED
);
	typedef struct packed {
		logic awready;
		logic aw_got;
		logic [7:0] awaddr;
		logic wready;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] sticky;
		logic [31:0] enable;
		logic out_req;
		logic in_req;
		logic [1:0] frame_end_point;
		logic tx_level;
		logic [1:0] speed;
		logic [10:0] frame;
		logic suspended;
		logic host;
		logic in_ep;
		logic dual;
		logic out_act;
		logic in_act;
		logic tx_half;
		logic tx_empty;
		logic rx_ne;
		logic irq;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic idle_expired;

	usb_idle_timer #(
		.CYCLES(IDLE_CYCLES)
	) u_idle (
		.clk(CLK),
		.rstn(RSTN),
		.idle(BUS_IDLE && !HOST_MODE),
		.expired(idle_expired)
	);

	// Registers that only make sense while the core acts as a device.
	function automatic logic device_only(input logic [7:0] addr);
		device_only = (addr == usb_flags_pkg::OFF_DEV_CTRL) ||
			(addr == usb_flags_pkg::OFF_DEV_CFG) ||
			(addr == usb_flags_pkg::OFF_DEV_STAT);
	endfunction

	function automatic logic mapped(input logic [7:0] addr);
		mapped = (addr == usb_flags_pkg::OFF_FLAGS) || (addr == usb_flags_pkg::OFF_ENABLE) ||
			device_only(addr) || (addr == usb_flags_pkg::OFF_BUS_CTRL);
	endfunction

	// Full flag word: sticky bits plus the live summary and level bits.
	function automatic logic [31:0] flag_view(input state_t s);
		logic [31:0] v;
		v = s.sticky;
		v[usb_flags_pkg::B_IN_EP] = s.in_ep && !s.host;
		v[usb_flags_pkg::B_DUAL] = s.dual;
		v[usb_flags_pkg::B_GLOBAL_OUT_NACK_ACTIVE] = s.out_act && !s.host;
		v[usb_flags_pkg::B_GINAK] = s.in_act && !s.host;
		v[usb_flags_pkg::B_NPTXFE] = s.host && (s.tx_level ? s.tx_empty : s.tx_half);
		v[usb_flags_pkg::B_RXFNE] = s.rx_ne;
		v[usb_flags_pkg::B_ROLE] = s.host;
		flag_view = v;
	endfunction

	function automatic logic [31:0] byte_mask(input logic [3:0] strb);
		byte_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	always_comb begin
		logic [31:0] wd;
		logic [31:0] wm;
		logic [31:0] set;
		logic [31:0] clr;
		logic fault;
		wd = '0;
		wm = '0;
		set = '0;
		clr = '0;
		fault = 1'b0;
		s_d = s_q;

		s_d.host = HOST_MODE;
		s_d.in_ep = IN_EP_PENDING;
		s_d.dual = DUAL_ROLE_PENDING;
		s_d.out_act = OUT_NACK_ACTIVE;
		s_d.in_act = IN_NACK_ACTIVE;
		s_d.tx_half = TX_HALF_EMPTY;
		s_d.tx_empty = TX_EMPTY;
		s_d.rx_ne = RX_NONEMPTY;

		// Write address and data are taken independently, in either order.
		if (AWVALID && s_q.awready) begin
			s_d.awaddr = AWADDR;
			s_d.aw_got = 1'b1;
		end
		if (WVALID && s_q.wready) begin
			s_d.wdata = WDATA;
			s_d.wstrb = WSTRB;
			s_d.w_got = 1'b1;
		end
		if (s_q.bvalid && BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = usb_flags_pkg::RESP_OKAY;
			wm = byte_mask(s_q.wstrb);
			wd = s_q.wdata & wm;
			if (!mapped(s_q.awaddr)) begin
				s_d.bresp = usb_flags_pkg::RESP_SLVERR;
			end else if (s_q.host && device_only(s_q.awaddr)) begin
				fault = 1'b1;
			end else begin
				unique case (s_q.awaddr)
					usb_flags_pkg::OFF_FLAGS: begin
						clr = wd & usb_flags_pkg::W1C_MASK;
					end
					usb_flags_pkg::OFF_ENABLE: begin
						s_d.enable = ((s_q.enable & ~wm) | wd) & usb_flags_pkg::ENABLE_MASK;
					end
					usb_flags_pkg::OFF_DEV_CTRL: begin
						// Set wins when software asks for both in one write.
						if (wd[usb_flags_pkg::B_CLR_OUT_NAK]) begin
							s_d.out_req = 1'b0;
						end
						if (wd[usb_flags_pkg::B_SET_OUT_NAK]) begin
							s_d.out_req = 1'b1;
						end
						if (wd[usb_flags_pkg::B_CLR_IN_NAK]) begin
							s_d.in_req = 1'b0;
						end
						if (wd[usb_flags_pkg::B_SET_IN_NAK]) begin
							s_d.in_req = 1'b1;
						end
					end
					usb_flags_pkg::OFF_DEV_CFG: begin
						if (wm[usb_flags_pkg::B_FRAME_END_LSB]) begin
							s_d.frame_end_point = wd[usb_flags_pkg::B_FRAME_END_LSB +: 2];
						end
					end
					usb_flags_pkg::OFF_BUS_CTRL: begin
						if (wm[usb_flags_pkg::B_TX_LEVEL]) begin
							s_d.tx_level = wd[usb_flags_pkg::B_TX_LEVEL];
						end
					end
					default: begin
					end
				endcase
			end
		end

		// Read channel: one read in flight, data registered one cycle after the address.
		if (s_q.rvalid && RREADY) begin
			s_d.rvalid = 1'b0;
			s_d.arready = 1'b1;
		end
		if (ARVALID && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rdata = '0;
			s_d.rresp = usb_flags_pkg::RESP_OKAY;
			if (!mapped(ARADDR)) begin
				s_d.rresp = usb_flags_pkg::RESP_SLVERR;
			end else if (s_q.host && device_only(ARADDR)) begin
				fault = 1'b1;
			end else begin
				unique case (ARADDR)
					usb_flags_pkg::OFF_FLAGS: begin
						s_d.rdata = flag_view(s_q);
					end
					usb_flags_pkg::OFF_ENABLE: begin
						s_d.rdata = s_q.enable;
					end
					usb_flags_pkg::OFF_DEV_CTRL: begin
						s_d.rdata[usb_flags_pkg::B_OUT_NAK_REQ] = s_q.out_req;
						s_d.rdata[usb_flags_pkg::B_IN_NAK_REQ] = s_q.in_req;
					end
					usb_flags_pkg::OFF_DEV_CFG: begin
						s_d.rdata[usb_flags_pkg::B_FRAME_END_LSB +: 2] = s_q.frame_end_point;
					end
					usb_flags_pkg::OFF_DEV_STAT: begin
						s_d.rdata[usb_flags_pkg::B_SUSPENDED] = s_q.suspended;
						s_d.rdata[usb_flags_pkg::B_SPEED_LSB +: 2] = s_q.speed;
						s_d.rdata[usb_flags_pkg::B_FRAME_LSB +: 11] = s_q.frame;
					end
					usb_flags_pkg::OFF_BUS_CTRL: begin
						s_d.rdata[usb_flags_pkg::B_TX_LEVEL] = s_q.tx_level;
					end
					default: begin
					end
				endcase
			end
		end

		// Hardware events; device-role events are gated by the sampled role.
		if (!s_q.host) begin
			set[usb_flags_pkg::B_EOPF] = FRAME_MARK && (FRAME_MARK_POINT == s_q.frame_end_point);
			set[usb_flags_pkg::B_ISO_DROP] = ISO_OUT_DROP;
			set[usb_flags_pkg::B_ENUM] = ENUM_DONE;
			set[usb_flags_pkg::B_RST] = BUS_RESET;
			set[usb_flags_pkg::B_SP] = idle_expired;
			set[usb_flags_pkg::B_ESP] = idle_expired;
			set[usb_flags_pkg::B_SOF] = SOF_RECEIVED;
		end else begin
			set[usb_flags_pkg::B_SOF] = SOF_PREPARE;
		end
		set[usb_flags_pkg::B_MF] = fault;
		if (!s_q.host && ENUM_DONE) begin
			s_d.speed = ENUM_SPEED;
		end
		if (!s_q.host && SOF_RECEIVED) begin
			s_d.frame = SOF_FRAME;
		end
		if (!BUS_IDLE || s_q.host) begin
			s_d.suspended = 1'b0;
		end else if (idle_expired) begin
			s_d.suspended = 1'b1;
		end

		// A set in the same cycle as a software clear wins, so no event is lost.
		s_d.sticky = ((s_q.sticky & ~clr) | set) & usb_flags_pkg::W1C_MASK;

		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready = !s_d.w_got && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
		// Enables only gate the request; they never touch the flags themselves.
		s_d.irq = |(flag_view(s_d) & s_d.enable);
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign AWREADY = s_q.awready;
	assign WREADY = s_q.wready;
	assign BVALID = s_q.bvalid;
	assign BRESP = s_q.bresp;
	assign ARREADY = s_q.arready;
	assign RVALID = s_q.rvalid;
	assign RDATA = s_q.rdata;
	assign RRESP = s_q.rresp;
	assign IRQ = s_q.irq;
	assign OUT_NACK_REQ = s_q.out_req;
	assign IN_NACK_REQ = s_q.in_req;
	assign SUSPENDED = s_q.suspended;
endmodule

// [usb_flags_pkg.sv]
// Shared constants for the global flag block: register map, bit positions and timing.
package usb_flags_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets.
	localparam logic [7:0] OFF_FLAGS = 8'h00;
	localparam logic [7:0] OFF_ENABLE = 8'h04;
	localparam logic [7:0] OFF_DEV_CTRL = 8'h08;
	localparam logic [7:0] OFF_DEV_CFG = 8'h0c;
	localparam logic [7:0] OFF_DEV_STAT = 8'h10;
	localparam logic [7:0] OFF_BUS_CTRL = 8'h14;

	// Bit positions in global_flags_reg.
	localparam int B_IN_EP = 18;
	localparam int B_EOPF = 15;
	localparam int B_ISO_DROP = 14;
	localparam int B_ENUM = 13;
	localparam int B_RST = 12;
	localparam int B_SP = 11;
	localparam int B_ESP = 10;
	localparam int B_GLOBAL_OUT_NACK_ACTIVE = 7;
	localparam int B_GINAK = 6;
	localparam int B_NPTXFE = 5;
	localparam int B_RXFNE = 4;
	localparam int B_SOF = 3;
	localparam int B_DUAL = 2;
	localparam int B_MF = 1;
	localparam int B_ROLE = 0;

	// Bits that software clears by writing 1; every other bit ignores writes.
	localparam logic [31:0] W1C_MASK = 32'h0000_fc0a;
	// Bits that may be enabled onto the interrupt request.
	localparam logic [31:0] ENABLE_MASK = 32'h0004_fcfe;

	// Device control register fields.
	localparam int B_SET_OUT_NAK = 0;
	localparam int B_CLR_OUT_NAK = 1;
	localparam int B_SET_IN_NAK = 2;
	localparam int B_CLR_IN_NAK = 3;
	localparam int B_OUT_NAK_REQ = 4;
	localparam int B_IN_NAK_REQ = 5;

	// Device config, device status and bus control fields.
	localparam int B_FRAME_END_LSB = 0;
	localparam int B_SUSPENDED = 0;
	localparam int B_SPEED_LSB = 1;
	localparam int B_FRAME_LSB = 8;
	localparam int B_TX_LEVEL = 0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Bus idle time before suspend.
	localparam int IDLE_TIME_US = 3000;
	localparam int CLK_MHZ = 100;
	localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
	localparam int IDLE_CNT_W = 20;
endpackage

// [usb_idle_timer.sv]
// Bus idle timer that pulses once after a full idle period.
`timescale 1ns/1ps
module usb_idle_timer #(
	parameter int CYCLES = usb_flags_pkg::IDLE_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic idle,
	output logic expired
);
	typedef struct packed {
		logic [usb_flags_pkg::IDLE_CNT_W-1:0] cnt;
		logic done;
		logic pulse;
	} timer_t;

	timer_t s_q;
	timer_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		if (!idle) begin
			// Any bus activity rearms the timer so the next idle period is seen fresh.
			s_d.cnt = '0;
			s_d.done = 1'b0;
		end else if (!s_q.done) begin
			if (s_q.cnt == usb_flags_pkg::IDLE_CNT_W'(CYCLES - 1)) begin
				s_d.done = 1'b1;
				s_d.pulse = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expired = s_q.pulse;
endmodule

// [usb_flags_properties.sv]
// Concurrent checks on the flag block's register bus and core-facing outputs.
`timescale 1ns/1ps
module usb_flags_checker (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic [1:0] BRESP,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RREADY,
	input wire logic HOST_MODE,
	input wire logic DUAL_ROLE_PENDING,
	input wire logic RX_NONEMPTY,
	input wire logic BUS_IDLE,
	input wire logic SUSPENDED,
	input wire logic OUT_NACK_REQ,
	input wire logic IN_NACK_REQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	sequence wr_taken;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence rd_flags;
		ARVALID && ARREADY && ARADDR == 8'h00;
	endsequence
	chk_write_answer: assert property (wr_taken |-> ##2 BVALID)
		else $error("write answer late");
	chk_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write answer dropped");
	chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read answer late");
	chk_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read answer dropped");
	chk_role_bit: assert property (rd_flags |=> RDATA[0] == $past(HOST_MODE, 2))
		else $error("role bit wrong");
	chk_rx_level: assert property (rd_flags |=> RDATA[4] == $past(RX_NONEMPTY, 2))
		else $error("rx flag wrong");
	chk_dual_level: assert property (rd_flags |=> RDATA[2] == $past(DUAL_ROLE_PENDING, 2))
		else $error("dual flag wrong");
	chk_wrong_role: assert property (ARVALID && ARREADY && ARADDR == 8'h10 && $past(HOST_MODE)
		|=> RDATA == 32'h0 && RRESP == 2'h0) else $error("host read of device reg");
	chk_suspend_cause: assert property ($rose(SUSPENDED)
		|-> $past(BUS_IDLE) && !$past(HOST_MODE, 2)) else $error("suspend without idle");
	chk_suspend_exit: assert property (!BUS_IDLE |-> ##[1:2] !SUSPENDED)
		else $error("suspend kept");
	chk_out_nak_req: assert property ($rose(OUT_NACK_REQ) |-> $rose(BVALID))
		else $error("out nak without write");
	chk_in_nak_req: assert property ($rose(IN_NACK_REQ) |-> $rose(BVALID))
		else $error("in nak without write");
endmodule
bind usb_flags_top usb_flags_checker i_usb_flags_checker (.*);

// [usb_far_model.sv]
// Behavioural model of the USB core and bus beside the flag block.
`timescale 1ns/1ps
module usb_far_model #(
	parameter int DLY = 4
) (
	input wire logic clk,
	input wire logic out_req,
	input wire logic in_req,
	output logic oa,
	output logic ia,
	output logic [5:0] ev
);
	logic [7:0] out_q, in_q;
	initial begin
		{oa, ia, ev, out_q, in_q} = '0;
	end
	// A NAK request takes effect only after DLY+2 cycles, as a real pipeline drains first.
	always @(posedge clk) begin
		out_q <= {out_q[6:0], out_req};
		in_q <= {in_q[6:0], in_req};
		oa <= out_q[DLY];
		ia <= in_q[DLY];
	end
	task pulse(input int i);
		@(posedge clk);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev[i] <= 1'b0;
	endtask
endmodule

// [usb_flags_top_tb.sv]
// Self-checking testbench for the global flag block.
`timescale 1ns/1ps
module usb_flags_top_tb;
	logic CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, HOST_MODE, IN_EP_PENDING;
	logic DUAL_ROLE_PENDING, BUS_IDLE, TX_HALF_EMPTY, TX_EMPTY, RX_NONEMPTY;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, OUT_NACK_REQ, IN_NACK_REQ, SUSPENDED, oa, ia;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, rd;
	logic [3:0] WSTRB;
	logic [1:0] FRAME_MARK_POINT, ENUM_SPEED, BRESP, RRESP, rr, rb;
	logic [10:0] SOF_FRAME;
	logic [5:0] ev;
	int failures, n_checks;
	usb_far_model i_usb_far_model (.clk(CLK), .out_req(OUT_NACK_REQ), .in_req(IN_NACK_REQ),
		.oa(oa), .ia(ia), .ev(ev));
	usb_flags_top #(.IDLE_CYCLES(20)) i_usb_flags_top (.FRAME_MARK(ev[0]), .ISO_OUT_DROP(ev[1]),
		.ENUM_DONE(ev[2]), .BUS_RESET(ev[3]), .SOF_PREPARE(ev[4]), .SOF_RECEIVED(ev[5]),
		.OUT_NACK_ACTIVE(oa), .IN_NACK_ACTIVE(ia), .*);
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task stop_test;
		if (failures == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Reserved bits are always written as zero.
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		AWADDR <= a;
		WDATA <= d;
		{AWVALID, WVALID, BREADY} <= 3'h7;
		forever begin
			@(posedge CLK);
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
			if (BVALID) break;
		end
		rb = BRESP;
		BREADY <= 1'b0;
	endtask
	task rdreg(input logic [7:0] a);
		@(posedge CLK);
		ARADDR <= a;
		{ARVALID, RREADY} <= 2'h3;
		forever begin
			@(posedge CLK);
			if (ARREADY) ARVALID <= 1'b0;
			if (RVALID) break;
		end
		rd = RDATA;
		rr = RRESP;
		RREADY <= 1'b0;
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rdreg(a);
		chk(n, rd & m, e);
	endtask
	task t_reset;
		rchk("flags", 8'h00, 32'hffffffff, 32'h0);
		rchk("enable", 8'h04, 32'hffffffff, 32'h0);
		rchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
		chk("unmapped resp", {30'h0, rr}, 32'h2);
		wr(8'h40, 32'h0);
		chk("unmapped wr resp", {30'h0, rb}, 32'h2);
		wr(8'h04, 32'h0);
		chk("wr resp", {30'h0, rb}, 32'h0);
	endtask
	task t_events;
		logic [31:0] m [6];
		m = '{32'h8000, 32'h4000, 32'h2000, 32'h1000, 32'h0, 32'h8};
		wr(8'h0c, 32'h2);
		i_usb_far_model.pulse(0);
		rchk("frame end early", 8'h00, 32'h8000, 32'h0);
		FRAME_MARK_POINT <= 2'h2;
		for (int i = 0; i < 6; i++) begin
			i_usb_far_model.pulse(i);
			wr(8'h00, 32'h0);
			rchk("event set", 8'h00, 32'hf008, m[i]);
			wr(8'h00, m[i]);
			rchk("event clear", 8'h00, 32'hf008, 32'h0);
		end
		rchk("status", 8'h10, 32'h7fffe, {13'h0, SOF_FRAME, 5'h0, ENUM_SPEED, 1'b0});
	endtask
	task t_irq;
		wr(8'h04, 32'h8000);
		i_usb_far_model.pulse(1);
		rchk("masked flag", 8'h00, 32'h4000, 32'h4000);
		chk("irq masked", {31'h0, IRQ}, 32'h0);
		i_usb_far_model.pulse(0);
		rdreg(8'h00);
		chk("irq", {31'h0, IRQ}, 32'h1);
		wr(8'h00, 32'hc000);
		chk("irq cleared", {31'h0, IRQ}, 32'h0);
	endtask
	task t_suspend;
		BUS_IDLE <= 1'b1;
		repeat (15) @(posedge CLK);
		chk("early", {31'h0, SUSPENDED}, 32'h0);
		repeat (10) @(posedge CLK);
		chk("suspended", {31'h0, SUSPENDED}, 32'h1);
		rchk("idle flags", 8'h00, 32'hc00, 32'hc00);
		rchk("status idle", 8'h10, 32'h1, 32'h1);
		BUS_IDLE <= 1'b0;
		wr(8'h00, 32'hc00);
		chk("resumed", {31'h0, SUSPENDED}, 32'h0);
	endtask
	task t_nak;
		for (int k = 0; k < 2; k++) begin
			wr(8'h08, 32'h1 << (2 * k));
			chk("nak req", {31'h0, k ? IN_NACK_REQ : OUT_NACK_REQ}, 32'h1);
			rchk("nak early", 8'h00, 32'h80 >> k, 32'h0);
			repeat (10) @(posedge CLK);
			rchk("nak active", 8'h00, 32'h80 >> k, 32'h80 >> k);
		end
		rchk("nak levels", 8'h08, 32'h30, 32'h30);
		wr(8'h08, 32'ha);
		repeat (10) @(posedge CLK);
		rchk("nak off", 8'h00, 32'hc0, 32'h0);
	endtask
	task t_levels;
		{IN_EP_PENDING, RX_NONEMPTY, DUAL_ROLE_PENDING} <= 3'h7;
		rchk("levels on", 8'h00, 32'h40014, 32'h40014);
		wr(8'h00, 32'h40014);
		rchk("levels kept", 8'h00, 32'h40014, 32'h40014);
		{IN_EP_PENDING, RX_NONEMPTY, DUAL_ROLE_PENDING} <= 3'h0;
		rchk("levels off", 8'h00, 32'h40014, 32'h0);
	endtask
	task t_host;
		HOST_MODE <= 1'b1;
		TX_HALF_EMPTY <= 1'b1;
		rchk("host role", 8'h00, 32'h23, 32'h21);
		rchk("device reg", 8'h10, 32'hffffffff, 32'h0);
		rchk("fault flag", 8'h00, 32'h2, 32'h2);
		wr(8'h14, 32'h1);
		rchk("tx half", 8'h00, 32'h20, 32'h0);
		TX_EMPTY <= 1'b1;
		rchk("tx full", 8'h00, 32'h20, 32'h20);
		i_usb_far_model.pulse(4);
		rchk("host sof", 8'h00, 32'h8, 32'h8);
		wr(8'h00, 32'h8);
		rchk("sof clear", 8'h00, 32'h8, 32'h0);
		wr(8'h08, 32'h1);
		chk("ignored write", {31'h0, OUT_NACK_REQ}, 32'h0);
	endtask
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial begin
		#200000;
		failures++;
		stop_test;
	end
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, HOST_MODE, IN_EP_PENDING} = '0;
		{DUAL_ROLE_PENDING, BUS_IDLE, TX_HALF_EMPTY, TX_EMPTY, RX_NONEMPTY} = '0;
		{AWADDR, ARADDR, WDATA, failures, n_checks} = '0;
		WSTRB = 4'hf;
		FRAME_MARK_POINT = 2'h1;
		ENUM_SPEED = 2'h3;
		SOF_FRAME = 11'h5a5;
		RSTN = 1'b0;
		repeat (4) @(posedge CLK);
		RSTN <= 1'b1;
		t_reset;
		t_events;
		t_irq;
		t_suspend;
		t_nak;
		t_levels;
		t_host;
		stop_test;
	end
endmodule
